// *** rtl/emb_ext_bus.v ***
`timescale 1ns/1ps
`include "emb_map.vh"
module emb_ext_bus (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire reset_pin,
  input wire external_access_select,
  input wire lock_programmed,
  input wire program_pulse_input,
  input wire [15:0] fetch_addr,
  input wire [15:0] data_addr,
  input wire [7:0] data_wdata,
  input wire [7:0] alt_p1_out,
  input wire [7:0] alt_p3_out,
  output wire [7:0] alt_p1_in,
  output wire [7:0] alt_p3_in,
  input wire [7:0] port0_in,
  output reg [7:0] port0_out,
  output reg [7:0] port0_oe,
  input wire [7:0] port1_in,
  output wire [7:0] port1_out,
  output wire [7:0] port1_oe,
  input wire [7:0] port2_in,
  output reg [7:0] port2_out,
  output reg [7:0] port2_oe,
  input wire [7:0] port3_in,
  output wire [7:0] port3_out,
  output wire [7:0] port3_oe,
  output reg addr_strobe,
  output reg addr_strobe_weak_pu,
  output reg program_fetch_strobe_n,
  output reg internal_reset,
  output wire fetch_external
);
  // ----------------------------------------
  // state machine codes for one machine cycle
  // ----------------------------------------
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  reg [7:0] p0_latch_r;
  reg [7:0] p1_latch_r;
  reg [7:0] p2_latch_r;
  reg [7:0] p3_latch_r;
  reg [7:0] strobe_ctl_r;
  reg [7:0] access_r;
  reg [2:0] phase_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [3:0] rst_cnt_r;
  reg ea_latched_r;
  reg ea_caught_r;
  reg [7:0] rdata_r;
  reg data_cycle_r;
  reg [7:0] code_byte_r;

  wire wr_en;
  wire rd_en;
  wire mc_end;
  wire disable_eff;
  wire ea_eff;
  wire [7:0] p1_drive;
  wire [7:0] p3_drive;

  // ----------------------------------------
  // apb slave, zero wait states
  // ----------------------------------------
  // one word per register: an unaligned address never selects anything
  function hit;
    input [9:0] a;
    input [7:0] ref_a;
    begin
      hit = (a == {ref_a, 2'b00});
    end
  endfunction

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;

  always @* begin
    rdata_r = 8'h00;
    if (hit(paddr, `EMB_ADDR_STROBE_CTL)) begin
      rdata_r = strobe_ctl_r;
    end else if (hit(paddr, `EMB_ADDR_PORT0)) begin
      rdata_r = port0_in;
    end else if (hit(paddr, `EMB_ADDR_PORT1)) begin
      rdata_r = port1_in;
    end else if (hit(paddr, `EMB_ADDR_PORT2)) begin
      rdata_r = port2_in;
    end else if (hit(paddr, `EMB_ADDR_PORT3)) begin
      rdata_r = port3_in;
    end else if (hit(paddr, `EMB_ADDR_ACCESS)) begin
      rdata_r = access_r;
    end else if (hit(paddr, `EMB_ADDR_STATUS)) begin
      rdata_r = {4'h0, ea_eff, disable_eff, data_cycle_r, internal_reset};
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en & ~penable) begin
      prdata <= {24'h000000, rdata_r};
    end
  end

  // ----------------------------------------
  // reset pin qualifier
  // ----------------------------------------
  // a glitch shorter than two machine cycles never resets the core
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_cnt_r <= 4'h0;
      internal_reset <= 1'b1;
    end else if (!reset_pin) begin
      rst_cnt_r <= 4'h0;
      internal_reset <= 1'b0;
    end else if (rst_cnt_r != `EMB_RESET_CYCLES - 1) begin
      rst_cnt_r <= rst_cnt_r + 4'h1;
    end else begin
      internal_reset <= 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p0_latch_r <= `EMB_PORT_RESET;
      p1_latch_r <= `EMB_PORT_RESET;
      p2_latch_r <= `EMB_PORT_RESET;
      p3_latch_r <= `EMB_PORT_RESET;
      strobe_ctl_r <= `EMB_STROBE_RESET;
      access_r <= 8'h00;
    end else if (internal_reset) begin
      p0_latch_r <= `EMB_PORT_RESET;
      p1_latch_r <= `EMB_PORT_RESET;
      p2_latch_r <= `EMB_PORT_RESET;
      p3_latch_r <= `EMB_PORT_RESET;
      strobe_ctl_r <= `EMB_STROBE_RESET;
      access_r <= 8'h00;
    end else begin
      if (wr_en && hit(paddr, `EMB_ADDR_PORT0)) begin
        p0_latch_r <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `EMB_ADDR_PORT1)) begin
        p1_latch_r <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `EMB_ADDR_PORT2)) begin
        p2_latch_r <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `EMB_ADDR_PORT3)) begin
        p3_latch_r <= pwdata[7:0];
      end
      if (wr_en && hit(paddr, `EMB_ADDR_STROBE_CTL)) begin
        strobe_ctl_r <= {7'h00, pwdata[`EMB_STROBE_DIS_BIT]};
      end
      // go is a request bit: hardware clears it when the data cycle starts
      if (wr_en && hit(paddr, `EMB_ADDR_ACCESS)) begin
        access_r <= pwdata[7:0];
      end else if (mc_end && state_r == ST_IDLE && access_r[`EMB_ACC_GO_BIT]) begin
        access_r[`EMB_ACC_GO_BIT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // access select strap
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ea_latched_r <= 1'b0;
      ea_caught_r <= 1'b0;
    end else if (internal_reset) begin
      ea_caught_r <= 1'b0;
    end else if (!ea_caught_r) begin
      ea_latched_r <= external_access_select;
      ea_caught_r <= 1'b1;
    end
  end

  // pin is active low: low selects external fetch of all code
  assign ea_eff = lock_programmed ? ea_latched_r : external_access_select;
  assign fetch_external = ~ea_eff | access_r[`EMB_ACC_EXTEXEC_BIT];

  // ----------------------------------------
  // machine cycle timing
  // ----------------------------------------
  assign mc_end = (phase_r == `EMB_STATES_PER_MC - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_r <= 3'h0;
    end else if (internal_reset || mc_end) begin
      phase_r <= 3'h0;
    end else begin
      phase_r <= phase_r + 3'h1;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (mc_end && access_r[`EMB_ACC_GO_BIT]) begin
          state_nxt = ST_DATA;
        end
      end
      ST_DATA: begin
        if (mc_end) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else if (internal_reset) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always @* begin
    data_cycle_r = (state_r == ST_DATA);
  end

  // ----------------------------------------
  // strobes
  // ----------------------------------------
  // the bit is honoured only when nothing suspends it; external execution overrides it
  assign disable_eff = strobe_ctl_r[`EMB_STROBE_DIS_BIT] & ~access_r[`EMB_ACC_SUSP_BIT]
                     & ~access_r[`EMB_ACC_CODE_BIT] & ~fetch_external;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_strobe <= 1'b0;
      program_fetch_strobe_n <= 1'b1;
    end else begin
      // one pulse per six clocks, dropped in the data cycle
      addr_strobe <= ~internal_reset & (phase_r == 3'h0) & ~data_cycle_r
                   & ~disable_eff;
      // two fetch strobes per cycle; both lost in the data cycle
      program_fetch_strobe_n <= ~(~internal_reset & fetch_external & ~data_cycle_r
                                & (phase_r == 3'h1 || phase_r == 3'h4));
    end
  end

  // ----------------------------------------
  // strobe pin pullup
  // ----------------------------------------
  // the pullup is registered from the effective bit, which would lag a reset
  // by one cycle, so the reset drops it directly
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_strobe_weak_pu <= 1'b0;
    end else if (internal_reset) begin
      addr_strobe_weak_pu <= 1'b0;
    end else begin
      addr_strobe_weak_pu <= disable_eff;
    end
  end

  // ----------------------------------------
  // programming mode code capture
  // ----------------------------------------
  // the pulse pin is taken as a level: it must be low across a clock edge
  // verify sends back the last byte taken, not the software latch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_byte_r <= 8'hFF;
    end else if (internal_reset) begin
      code_byte_r <= 8'hFF;
    end else if (access_r[`EMB_ACC_PGM_BIT] && !access_r[`EMB_ACC_VERIFY_BIT] && !program_pulse_input) begin
      code_byte_r <= port0_in;
    end
  end

  // ----------------------------------------
  // port zero and port two
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port0_out <= 8'h00;
      port0_oe <= 8'h00;
      port2_out <= 8'h00;
      port2_oe <= 8'h00;
    end else if (access_r[`EMB_ACC_PGM_BIT]) begin
      // verify drives code byte; program mode only listens
      port0_out <= code_byte_r;
      port0_oe <= access_r[`EMB_ACC_VERIFY_BIT] ? 8'hFF : 8'h00;
      port2_out <= p2_latch_r;
      port2_oe <= ~p2_latch_r;
    end else if (data_cycle_r) begin
      // address then data; the address is always driven, the data only on a write
      // no strobe here, so an outside latch keeps the last fetch address
      port0_out <= (phase_r < 3'h2) ? data_addr[7:0] : data_wdata;
      port0_oe <= (phase_r < 3'h2 || access_r[`EMB_ACC_WRITE_BIT]) ? 8'hFF : 8'h00;
      port2_out <= access_r[`EMB_ACC_WIDE_BIT] ? data_addr[15:8] : p2_latch_r;
      port2_oe <= access_r[`EMB_ACC_WIDE_BIT] ? 8'hFF : ~p2_latch_r;
    end else if (fetch_external) begin
      port0_out <= fetch_addr[7:0];
      port0_oe <= (phase_r == 3'h0 || phase_r == 3'h3) ? 8'hFF : 8'h00;
      port2_out <= fetch_addr[15:8];
      port2_oe <= 8'hFF;
    end else begin
      // open drain: only zeros are driven
      port0_out <= 8'h00;
      port0_oe <= ~p0_latch_r;
      port2_out <= 8'h00;
      port2_oe <= ~p2_latch_r;
    end
  end

  // ----------------------------------------
  // port one and port three with alternates
  // ----------------------------------------
  // a pin's alternate output only works while its latch holds one
  assign p1_drive = p1_latch_r & alt_p1_out;
  assign p3_drive = p3_latch_r & alt_p3_out;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_quasi
      // pullup outside; low is the only level driven
      assign port1_out[gi] = 1'b0;
      assign port1_oe[gi] = ~p1_drive[gi];
      assign port3_out[gi] = 1'b0;
      assign port3_oe[gi] = ~(p3_drive[gi] & ~(data_cycle_r & (gi == 6 || gi == 7)
                            & (phase_r > 3'h1)
                            & ((gi == 6) == access_r[`EMB_ACC_WRITE_BIT])));
    end
  endgenerate

  assign alt_p1_in = port1_in;
  assign alt_p3_in = port3_in;
endmodule

// *** shared/emb_map.vh ***
`ifndef EMB_MAP_VH
`define EMB_MAP_VH
// ----------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------
`define EMB_ADDR_STROBE_CTL 8'h8E
`define EMB_ADDR_PORT0 8'h80
`define EMB_ADDR_PORT1 8'h90
`define EMB_ADDR_PORT2 8'hA0
`define EMB_ADDR_PORT3 8'hB0
`define EMB_ADDR_ACCESS 8'hC0
`define EMB_ADDR_STATUS 8'hC4
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define EMB_STROBE_DIS_BIT 0
`define EMB_ACC_GO_BIT 0
`define EMB_ACC_WRITE_BIT 1
`define EMB_ACC_WIDE_BIT 2
`define EMB_ACC_CODE_BIT 3
`define EMB_ACC_SUSP_BIT 4
`define EMB_ACC_EXTEXEC_BIT 5
`define EMB_ACC_PGM_BIT 6
`define EMB_ACC_VERIFY_BIT 7
`define EMB_PORT_RESET 8'hFF
`define EMB_STROBE_RESET 8'h00
// ----------------------------------------
// timing counts
// ----------------------------------------
`define EMB_STATES_PER_MC 6
`define EMB_RESET_MC 2
`define EMB_RESET_CYCLES (`EMB_STATES_PER_MC * `EMB_RESET_MC)
`endif

// *** verif/emb_ext_bus_chk.sv ***
`timescale 1ns/1ps
module emb_ext_bus_chk (
  input wire pclk,
  input wire presetn,
  input wire reset_pin,
  input wire addr_strobe,
  input wire addr_strobe_weak_pu,
  input wire program_fetch_strobe_n,
  input wire internal_reset,
  input wire fetch_external,
  input wire [7:0] port1_out,
  input wire [7:0] port3_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_STROBE_GAP: assert property ($rose(addr_strobe) |=> !addr_strobe [*5])
    else $error("address strobe closer than six cycles");
  AST_WEAK_QUIET: assert property (addr_strobe_weak_pu |-> !addr_strobe)
    else $error("strobe pulses while disabled");
  AST_EXT_NO_WEAK: assert property (fetch_external && $past(fetch_external) |-> !addr_strobe_weak_pu)
    else $error("disable acts during external execution");
  AST_RESET_CLR: assert property (internal_reset |=> !addr_strobe_weak_pu)
    else $error("reset left strobe disabled");
  AST_RESET_SHORT: assert property ($rose(reset_pin) && !internal_reset ##1 reset_pin [*8] |-> !internal_reset)
    else $error("reset taken too early");
  AST_RESET_LONG: assert property (reset_pin [*8] ##1 reset_pin [*6] |-> internal_reset)
    else $error("long reset pulse not taken");
  AST_FETCH_EXT: assert property (!program_fetch_strobe_n |-> $past(fetch_external))
    else $error("fetch strobe during internal execution");
  AST_FETCH_PAIR: assert property ($rose(addr_strobe) && fetch_external |-> ##[1:5] !program_fetch_strobe_n)
    else $error("no fetch strobe after address strobe");
  AST_PORT_PULL: assert property (port1_out == 8'h00 && port3_out == 8'h00)
    else $error("quasi port drives high");
  cover property (addr_strobe_weak_pu);
  cover property (!program_fetch_strobe_n);
  cover property ($fell(internal_reset));
endmodule
bind emb_ext_bus emb_ext_bus_chk u_chk (.pclk(pclk), .presetn(presetn), .reset_pin(reset_pin),
  .addr_strobe(addr_strobe), .addr_strobe_weak_pu(addr_strobe_weak_pu),
  .program_fetch_strobe_n(program_fetch_strobe_n), .internal_reset(internal_reset),
  .fetch_external(fetch_external), .port1_out(port1_out), .port3_out(port3_out));

// *** verif/emb_mem_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// external code memory behind a low-address latch
// ----------------------------------------
module emb_mem_model (
  input wire pclk,
  input wire presetn,
  input wire addr_strobe,
  input wire program_fetch_strobe_n,
  input wire [7:0] port0_pin,
  output logic [7:0] mem_data,
  output logic mem_en
);
  logic [7:0] low_addr_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) low_addr_r <= 8'h00;
    else if (addr_strobe) low_addr_r <= port0_pin;
  end
  // code byte derived from address so a stale latch shows up
  assign mem_data = low_addr_r ^ 8'hA5;
  assign mem_en = !program_fetch_strobe_n;
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, reset_pin = 0, ea_sel = 1, seen_hi = 0;
  logic [7:0] p1_ext = 8'hFF;
  logic [9:0] paddr = 10'h000;
  logic lock_sel = 0;
  logic [15:0] data_addr = 16'h0000;
  logic [31:0] pwdata = 32'h0, rd;
  wire [31:0] prdata;
  wire pready, as, as_pu, fetch_n, irst, fext, mem_en;
  wire [7:0] p0_out, p0_oe, p1_out, p1_oe, p2_out, p2_oe, p3_out, p3_oe, mem_data;
  wire [7:0] p0_pin = (p0_oe & p0_out) | (~p0_oe & (mem_en ? mem_data : 8'hFF));
  wire [7:0] p1_pin = (p1_oe & p1_out) | (~p1_oe & p1_ext);
  wire [7:0] p2_pin = (p2_oe & p2_out) | ~p2_oe;
  wire [7:0] p3_pin = (p3_oe & p3_out) | ~p3_oe;
  int error_cnt = 0, n_compared = 0, na, nf;
  always #50 pclk = ~pclk;
  always @(posedge pclk) if (p2_oe == 8'hFF && p2_out == 8'h12) seen_hi <= 1'b1;
  emb_ext_bus u_emb_ext_bus (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(),
    .reset_pin(reset_pin), .external_access_select(ea_sel), .lock_programmed(lock_sel),
    .program_pulse_input(1'b0), .fetch_addr(16'h0123), .data_addr(data_addr), .data_wdata(8'h5A),
    .alt_p1_out(8'hFF), .alt_p3_out(8'hFF), .alt_p1_in(), .alt_p3_in(), .port0_in(p0_pin),
    .port0_out(p0_out), .port0_oe(p0_oe), .port1_in(p1_pin), .port1_out(p1_out), .port1_oe(p1_oe),
    .port2_in(p2_pin), .port2_out(p2_out), .port2_oe(p2_oe), .port3_in(p3_pin), .port3_out(p3_out),
    .port3_oe(p3_oe), .addr_strobe(as), .addr_strobe_weak_pu(as_pu), .program_fetch_strobe_n(fetch_n),
    .internal_reset(irst), .fetch_external(fext));
  emb_mem_model u_emb_mem_model (.pclk(pclk), .presetn(presetn), .addr_strobe(as),
    .program_fetch_strobe_n(fetch_n), .port0_pin(p0_pin), .mem_data(mem_data), .mem_en(mem_en));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk); psel <= 1; pwrite <= w; paddr <= {a, 2'b00}; pwdata <= d;
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; psel <= 0; penable <= 0;
  endtask
  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin error_cnt++; $display("BAD %s exp %h got %h", nm, exp, got); end
  endtask
  task automatic count(input int n);
    na = 0; nf = 0;
    repeat (n) begin @(posedge pclk); na += (as === 1'b1); nf += (fetch_n === 1'b0); end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    apb(0, 8'h8E, 0); cmp("strobe_ctl reset", 0, rd);
    apb(1, 8'h8E, 1); apb(0, 8'h8E, 0); cmp("strobe_ctl", 1, rd);
    count(12); cmp("strobes disabled", 0, na);
    cmp("weak pullup", 1, as_pu);
    apb(1, 8'hC0, 8); count(2); cmp("weak pullup suspended", 0, as_pu);
    apb(0, 8'hF0, 0); cmp("unmapped read", 0, rd);
    apb(1, 8'hC0, 0); apb(1, 8'h8E, 0);
    $display("done regs");
  endtask
  task automatic t_ports();
    cmp("port0 float", 0, p0_oe);
    p1_ext <= 8'h3C; apb(0, 8'h90, 0); cmp("port1 pins", 8'h3C, rd);
    apb(1, 8'h90, 8'h0F); @(posedge pclk); cmp("port1 oe", 8'hF0, p1_oe);
    apb(0, 8'h90, 0); cmp("port1 mixed", 8'h0C, rd);
    apb(1, 8'h90, 8'hFF); p1_ext <= 8'hFF;
    $display("done ports");
  endtask
  task automatic t_ext();
    count(60); cmp("strobe rate", 10, na);
    cmp("internal fetch", 0, nf);
    ea_sel <= 0; count(2); cmp("fetch source", 1, fext);
    count(60); cmp("fetch rate", 20, nf);
    cmp("latched low address", 8'h23 ^ 8'hA5, mem_data);
    apb(1, 8'h8E, 1); count(12); cmp("disable ignored", 2, na);
    cmp("no weak pullup", 0, as_pu);
    apb(1, 8'h8E, 0); data_addr <= 16'h12C4;
    apb(1, 8'hC0, 5); count(36); cmp("strobe skip", 5, na);
    cmp("fetch skip", 10, nf);
    cmp("high address", 1, seen_hi);
    ea_sel <= 1;
    $display("done external");
  endtask
  task automatic t_reset();
    lock_sel <= 1; ea_sel <= 0; count(2); cmp("locked select held", 0, fext);
    apb(0, 8'hC4, 0); cmp("status select", 8'h08, rd);
    apb(1, 8'h8E, 1);
    reset_pin <= 1; repeat (16) @(posedge pclk);
    cmp("internal reset", 1, irst);
    reset_pin <= 0; repeat (3) @(posedge pclk);
    apb(0, 8'h8E, 0); cmp("strobe_ctl cleared", 0, rd);
    ea_sel <= 1; count(2); cmp("select latched at reset", 1, fext);
    lock_sel <= 0;
    $display("done reset");
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs(); t_ports(); t_ext(); t_reset();
    tally_and_finish();
  end
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
endmodule
